// file: design/tlic_top.sv
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - All sources maskable, combined into one fast and one normal processor interrupt.
// - Raw pending is 32 bits, read-only; writes leave it alone.
// - Raw pending shows requests regardless of mask bits.
// - Raw pending shows fast-routed and normal-routed sources alike.
// - Normal view holds only active sources routed to normal.
// - Fast view holds only active sources routed to fast.
// - Sources enabled in their unit and unmasked here; no enables held here.
// - In idle any enabled request wakes the processor.
// - With idle-mask-disable zero, mask ignored during idle.
// - Mask and routing undefined after reset, control resets to zero; software sets mask and routing first.
// - Bit 31 alarm match, bit 30 one-hertz tick.
// - Bits 29 to 26 timer matches 3 to 0.
// - Bits 25 to 20 DMA channels 5 to 0.
// - Bits 19 to 12 serial, codec, uarts, reserved, USB, LCD.
// - Bit 11 is OR of pin edge flags 27 to 11.
// - Bits 10 to 0 carry pin edge flags 10 to 0.
// - Mask one lets a source become active, zero blocks it.
// - Routing bit matters for unmasked sources, and for every source in idle with idle-mask-disable zero.
// - Mask register is not initialised by reset.
module tlic_top (
   input  wire logic                          clk_i,
   input  wire logic                          resetn_i,
   input  wire logic [tlic_pkg::ADDR_W-1:0]   avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [tlic_pkg::DATA_W-1:0]   avs_writedata_i,
   input  wire logic [tlic_pkg::BE_W-1:0]     avs_byteenable_i,
   output logic      [tlic_pkg::DATA_W-1:0]   avs_readdata_o,
   output logic                               avs_waitrequest_o,
   input  wire logic                          rtc_alarm_i,
   input  wire logic                          rtc_hz_i,
   input  wire logic [3:0]                    ostimer_match_i,
   input  wire logic [5:0]                    dma_req_i,
   input  wire logic                          sync_serial_port_i,
   input  wire logic                          multimedia_codec_port_i,
   input  wire logic                          uart3_req_i,
   input  wire logic                          uart2_high_speed_serial_port_i,
   input  wire logic                          uart1_req_i,
   input  wire logic                          usb_device_port_i,
   input  wire logic                          lcd_req_i,
   input  wire logic [tlic_pkg::GPIO_N-1:0]   gpio_edge_i,
   input  wire logic                          cpu_idle_i,
   output logic                               normal_irq_o,
   output logic                               fast_irq_o,
   output logic                               wake_o
);
   import tlic_pkg::*;

   // ---------------------------------------------------------------
   // Raw pending assembly
   // ---------------------------------------------------------------
   // Requests come from same-clock units; pin flags 27 to 11 are ORed here
   logic [NSRC-1:0] raw_pending;

   genvar g;
   generate
      for (g = 0; g < GPIO_SINGLE; g++) begin : g_gpio
         assign raw_pending[g] = gpio_edge_i[g];
      end
   endgenerate

   assign raw_pending[BIT_GPIO_OR]   = |gpio_edge_i[GPIO_N-1:GPIO_SINGLE];
   assign raw_pending[BIT_LCD]       = lcd_req_i;
   assign raw_pending[BIT_USB]       = usb_device_port_i;
   assign raw_pending[BIT_RSVD]      = 1'b0;
   assign raw_pending[BIT_UART1]     = uart1_req_i;
   assign raw_pending[BIT_UART2]     = uart2_high_speed_serial_port_i;
   assign raw_pending[BIT_UART3]     = uart3_req_i;
   assign raw_pending[BIT_MCP]       = multimedia_codec_port_i;
   assign raw_pending[BIT_SSP]       = sync_serial_port_i;
   assign raw_pending[BIT_DMA_LO+5:BIT_DMA_LO] = dma_req_i;
   assign raw_pending[BIT_OST_LO+3:BIT_OST_LO] = ostimer_match_i;
   assign raw_pending[BIT_RTC_HZ]    = rtc_hz_i;
   assign raw_pending[BIT_RTC_ALARM] = rtc_alarm_i;

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mask_r;
   logic [DATA_W-1:0] mask_nxt;
   logic [DATA_W-1:0] route_r;
   logic [DATA_W-1:0] route_nxt;
   logic              mask_set_r;
   logic              mask_set_nxt;
   logic              route_set_r;
   logic              route_set_nxt;
   logic              dim_r;
   logic              dim_nxt;
   logic              ack_r;
   logic              ack_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic              nirq_r;
   logic              nirq_nxt;
   logic              firq_r;
   logic              firq_nxt;
   logic              wake_r;
   logic              wake_nxt;

   logic [DATA_W-1:0] be_mask;
   logic [DATA_W-1:0] mask_eff;
   logic [DATA_W-1:0] route_eff;
   logic [DATA_W-1:0] active;
   logic [DATA_W-1:0] normal_view;
   logic [DATA_W-1:0] fast_view;
   logic              do_wr;
   logic              idle_bypass;

   // ---------------------------------------------------------------
   // Combining logic
   // ---------------------------------------------------------------
   // Unwritten mask or routing holds unknown bits; the combining logic takes them as zero, so the
   // mask blocks (idle bypass aside) and every source routes to normal.
   // gate until initialised
   assign mask_eff  = mask_set_r  ? mask_r  : RST_ZERO;
   assign route_eff = route_set_r ? route_r : RST_ZERO;

   assign idle_bypass = cpu_idle_i & ~dim_r;

   assign active      = raw_pending & (mask_eff | {DATA_W{idle_bypass}});
   assign normal_view = active & ~route_eff;
   assign fast_view   = active & route_eff;

   always_comb begin
      nirq_nxt = |normal_view;
      firq_nxt = |fast_view;
      wake_nxt = cpu_idle_i & (|active);
   end

   // ---------------------------------------------------------------
   // Avalon slave
   // ---------------------------------------------------------------
   // One wait cycle per access: read data settles in a flop first
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
   assign do_wr             = avs_write_i & ack_r;

   generate
      for (g = 0; g < BE_W; g++) begin : g_be
         assign be_mask[8*g+7:8*g] = {8{avs_byteenable_i[g]}};
      end
   endgenerate

   always_comb begin
      ack_nxt       = (avs_read_i | avs_write_i) & ~ack_r;
      rdata_nxt     = rdata_r;
      mask_nxt      = mask_r;
      route_nxt     = route_r;
      mask_set_nxt  = mask_set_r;
      route_set_nxt = route_set_r;
      dim_nxt       = dim_r;
      if (avs_read_i & ~ack_r) begin
         case (avs_address_i)
            OFS_NORMAL_VIEW: rdata_nxt = normal_view;
            OFS_FAST_VIEW:   rdata_nxt = fast_view;
            OFS_MASK:        rdata_nxt = mask_r;
            OFS_ROUTING:     rdata_nxt = route_r;
            OFS_CONTROL:     rdata_nxt = {{(DATA_W-1){1'b0}}, dim_r};
            OFS_RAW_PENDING: rdata_nxt = raw_pending;
            default:         rdata_nxt = RST_ZERO;
         endcase
      end
      if (do_wr) begin
         case (avs_address_i)
            OFS_MASK: begin
               mask_nxt     = (mask_r & ~be_mask) | (avs_writedata_i & be_mask);
               mask_set_nxt = 1'b1;
            end
            OFS_ROUTING: begin
               route_nxt     = (route_r & ~be_mask) | (avs_writedata_i & be_mask);
               route_set_nxt = 1'b1;
            end
            OFS_CONTROL: begin
               if (avs_byteenable_i[0]) begin
                  dim_nxt = avs_writedata_i[CTRL_DIM_BIT];
               end
            end
            default: begin
               dim_nxt = dim_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      mask_r  <= mask_nxt;
      route_r <= route_nxt;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mask_set_r  <= 1'b0;
         route_set_r <= 1'b0;
         dim_r       <= RST_DIM;
         ack_r       <= 1'b0;
         rdata_r     <= RST_ZERO;
         nirq_r      <= 1'b0;
         firq_r      <= 1'b0;
         wake_r      <= 1'b0;
      end else begin
         mask_set_r  <= mask_set_nxt;
         route_set_r <= route_set_nxt;
         dim_r       <= dim_nxt;
         ack_r       <= ack_nxt;
         rdata_r     <= rdata_nxt;
         nirq_r      <= nirq_nxt;
         firq_r      <= firq_nxt;
         wake_r      <= wake_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // three processor lines
   assign normal_irq_o   = nirq_r;
   assign fast_irq_o     = firq_r;
   assign wake_o         = wake_r;
   assign avs_readdata_o = rdata_r;
endmodule

// file: design/tlic_pkg.sv
package tlic_pkg;
   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned BE_W   = 4;
   localparam int unsigned NSRC   = 32;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_NORMAL_VIEW = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_MASK        = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_ROUTING     = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_CONTROL     = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_FAST_VIEW   = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_RAW_PENDING = 6'h20;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTRL_DIM_BIT  = 0;
   localparam int unsigned BIT_RTC_ALARM = 31;
   localparam int unsigned BIT_RTC_HZ    = 30;
   localparam int unsigned BIT_OST_LO    = 26;
   localparam int unsigned BIT_DMA_LO    = 20;
   localparam int unsigned BIT_SSP       = 19;
   localparam int unsigned BIT_MCP       = 18;
   localparam int unsigned BIT_UART3     = 17;
   localparam int unsigned BIT_UART2     = 16;
   localparam int unsigned BIT_UART1     = 15;
   localparam int unsigned BIT_RSVD      = 14;
   localparam int unsigned BIT_USB       = 13;
   localparam int unsigned BIT_LCD       = 12;
   localparam int unsigned BIT_GPIO_OR   = 11;
   localparam int unsigned GPIO_SINGLE   = 11;
   localparam int unsigned GPIO_N        = 28;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
   localparam logic              RST_DIM  = 1'b0;
endpackage

// file: verification/tlic_monitor.sv
`timescale 1ns/1ps
// ----------
// Port checker
// ----------
module tlic_monitor (
   input wire logic                        clk_i,
   input wire logic                        resetn_i,
   input wire logic [tlic_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic                        avs_read_i,
   input wire logic                        avs_write_i,
   input wire logic [tlic_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [tlic_pkg::BE_W-1:0]   avs_byteenable_i,
   input wire logic [tlic_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic                        avs_waitrequest_o,
   input wire logic [tlic_pkg::GPIO_N-1:0] gpio_edge_i,
   input wire logic                        cpu_idle_i,
   input wire logic                        normal_irq_o,
   input wire logic                        fast_irq_o,
   input wire logic                        wake_o
);
   import tlic_pkg::*;
   logic dim_r, dim_nxt, raw_rd;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Shadow of the idle-mask bit; only byte lane 0 can change it
   always_comb begin
      dim_nxt = dim_r;
      if (avs_write_i && !avs_waitrequest_o && avs_address_i == OFS_CONTROL && avs_byteenable_i[0]) begin
         dim_nxt = avs_writedata_i[CTRL_DIM_BIT];
      end
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dim_r <= RST_DIM;
      end else begin
         dim_r <= dim_nxt;
      end
   end
   assign raw_rd = avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_RAW_PENDING;
   first_wait_a: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
      else $error("read answered with no wait cycle");
   answer_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait");
   raw_low_a: assert property (raw_rd |-> avs_readdata_o[10:0] == 11'($past(gpio_edge_i)))
      else $error("raw low pin bits wrong");
   raw_or_a: assert property (raw_rd |-> avs_readdata_o[11] == |($past(gpio_edge_i) & 28'hFFFF800))
      else $error("raw pin OR bit wrong");
   rsvd_zero_a: assert property (raw_rd |-> !avs_readdata_o[BIT_RSVD])
      else $error("reserved bit set");
   idle_wake_a: assert property (!cpu_idle_i |=> !wake_o)
      else $error("wake outside idle");
   dim_bypass_a: assert property (cpu_idle_i && !dim_r && gpio_edge_i != '0 |=> wake_o)
      else $error("idle bypass gave no wake");
   bypass_irq_a: assert property (cpu_idle_i && !dim_r && gpio_edge_i != '0 |=> normal_irq_o || fast_irq_o)
      else $error("idle bypass gave no interrupt");
endmodule

bind tlic_top tlic_monitor u_mon (
   .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .gpio_edge_i(gpio_edge_i),
   .cpu_idle_i(cpu_idle_i), .normal_irq_o(normal_irq_o), .fast_irq_o(fast_irq_o), .wake_o(wake_o)
);

// file: verification/tlic_cpu_model.sv
`timescale 1ns/1ps
// ----------
// Processor idle stand-in
// ----------
module tlic_cpu_model (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic sleep_req_i,
   input  wire logic wake_i,
   output logic      cpu_idle_o
);
   logic idle_r, idle_nxt;
   // Wake wins over a pending sleep request, as a real core would resume
   always_comb begin
      idle_nxt = idle_r;
      if (wake_i) begin
         idle_nxt = 1'b0;
      end else if (sleep_req_i) begin
         idle_nxt = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         idle_r <= 1'b0;
      end else begin
         idle_r <= idle_nxt;
      end
   end
   assign cpu_idle_o = idle_r;
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
// ----------
// Self-checking bench
// ----------
module tb_top;
   import tlic_pkg::*;
   logic              clk_i, resetn_i, rd, wr, waitreq, idle, sleep_req, nirq, firq, wake;
   logic [ADDR_W-1:0] addr;
   logic [BE_W-1:0]   be;
   logic [DATA_W-1:0] wdata, rdata, mask, route, q;
   logic [18:0]       misc;
   logic [GPIO_N-1:0] gpio;
   int                fails, cmp_count, seed, n;
   tlic_top u_dut (
      .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .rtc_alarm_i(misc[18]), .rtc_hz_i(misc[17]), .ostimer_match_i(misc[16:13]), .dma_req_i(misc[12:7]),
      .sync_serial_port_i(misc[6]), .multimedia_codec_port_i(misc[5]), .uart3_req_i(misc[4]),
      .uart2_high_speed_serial_port_i(misc[3]), .uart1_req_i(misc[2]), .usb_device_port_i(misc[1]),
      .lcd_req_i(misc[0]), .gpio_edge_i(gpio), .cpu_idle_i(idle), .normal_irq_o(nirq), .fast_irq_o(firq),
      .wake_o(wake)
   );
   tlic_cpu_model u_cpu (.clk_i(clk_i), .resetn_i(resetn_i), .sleep_req_i(sleep_req), .wake_i(wake),
      .cpu_idle_o(idle));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   function automatic logic [DATA_W-1:0] raw_f();
      return {misc[18:2], 1'b0, misc[1:0], |gpio[27:11], gpio[10:0]};
   endfunction
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Request held until waitrequest is seen low, released on the following edge
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= w;
      rd    <= !w;
      do begin
         @(negedge clk_i);
         k++;
      end while (waitreq !== 1'b0 && k < 50);
      q = rdata;
      @(posedge clk_i);
      rd <= 1'b0;
      wr <= 1'b0;
      if (k >= 50) begin
         fails++;
         finish_test();
      end
   endtask
   initial begin
      seed = 92;
      fails = 0;
      cmp_count = 0;
      {resetn_i, rd, wr, sleep_req, addr, wdata, misc, gpio} = '0;
      be = 4'hF;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      bus(1'b1, OFS_CONTROL, 32'h0000_0001);
      for (int i = 0; i < 48; i++) begin
         if (i % 12 == 0) begin
            mask  = $random(seed);
            route = $random(seed);
            bus(1'b1, OFS_MASK, mask);
            bus(1'b1, OFS_ROUTING, route);
         end
         misc <= (i == 0) ? 19'h00000 : 19'($random(seed));
         gpio <= (i == 0) ? 28'h0100000 : 28'($random(seed));
         @(posedge clk_i);
         @(negedge clk_i);
         chk("normal_irq", 32'(nirq), 32'(|(raw_f() & mask & ~route)));
         chk("fast_irq", 32'(firq), 32'(|(raw_f() & mask & route)));
         bus(1'b0, OFS_RAW_PENDING, '0);
         chk("raw", q, raw_f());
         bus(1'b0, OFS_NORMAL_VIEW, '0);
         chk("normal_view", q, raw_f() & mask & ~route);
         bus(1'b0, OFS_FAST_VIEW, '0);
         chk("fast_view", q, raw_f() & mask & route);
      end
      bus(1'b1, OFS_RAW_PENDING, 32'hFFFF_FFFF);
      bus(1'b0, OFS_RAW_PENDING, '0);
      chk("raw_ro", q, raw_f());
      bus(1'b0, 6'h3C, '0);
      chk("unmapped", q, 32'h0000_0000);
      be <= 4'h1;
      bus(1'b1, OFS_MASK, 32'h0000_00A5);
      be <= 4'hF;
      bus(1'b0, OFS_MASK, '0);
      chk("mask_lane", q, {mask[31:8], 8'hA5});
      misc <= '0;
      gpio <= 28'h0000001;
      for (int c = 0; c < 3; c++) begin
         bus(1'b1, OFS_CONTROL, (c == 0) ? 32'h0000_0000 : 32'h0000_0001);
         bus(1'b1, OFS_MASK, (c == 2) ? 32'hFFFF_FFFF : 32'h0000_0000);
         sleep_req <= 1'b1;
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (wake !== 1'b1 && n < 8);
         sleep_req <= 1'b0;
         chk("wake", 32'(n < 8), 32'(c != 1));
      end
      finish_test();
   end
endmodule
